// ### lmc_pkg.sv
// Package for the lane output muting control block: register map, field layout, reset values.
// Assumes an APB slave with 32-bit data, one register per aligned word.
package lmc_pkg;
  localparam int LANES = 8;
  // Offsets are word indices, not byte addresses; byte address = 4 * index
  localparam logic [7:0] IDX_TX_IN_INVERT     = 8'h81;
  localparam logic [7:0] IDX_TX_OUT_OFF       = 8'h82;
  localparam logic [7:0] IDX_TX_AUTO_MUTE_OFF = 8'h83;
  localparam logic [7:0] IDX_TX_OUT_MUTE_FRC  = 8'h84;
  localparam logic [7:0] IDX_TX_EQ_ADAPT_HOLD = 8'h86;
  localparam logic [7:0] IDX_TX_EQ_SAVE_LO    = 8'h87;
  localparam logic [7:0] IDX_TX_EQ_SAVE_HI    = 8'h88;
  localparam logic [7:0] IDX_RX_OUT_INVERT    = 8'h89;
  // Extra registers for controls and status that have no byte of their own
  localparam logic [7:0] IDX_RX_OUT_OFF       = 8'hA0;
  localparam logic [7:0] IDX_RX_AUTO_MUTE_OFF = 8'hA1;
  localparam logic [7:0] IDX_TX_MUTE_STATUS   = 8'hA2;
  localparam logic [7:0] IDX_RX_MUTE_STATUS   = 8'hA3;
  localparam logic [7:0] IDX_EQ_SAVE_COUNT    = 8'hA4;
  localparam logic [7:0] RST_BYTE             = 8'h00;
  // Save slot codes
  localparam logic [1:0] EQ_SLOT_ONE = 2'h1;
  localparam logic [1:0] EQ_SLOT_TWO = 2'h2;
  localparam int         SLOT_W      = 2;
endpackage

// ### lmc_sync.sv
// Two-flop synchroniser for a vector of level inputs.
// Assumes inputs are levels from outside the pclk domain.
`timescale 1ns/1ps
module lmc_sync #(
  parameter int W = 8
) (
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);
  logic [W-1:0] meta_q;
  logic [W-1:0] meta_d;
  logic [W-1:0] sync_q;
  logic [W-1:0] sync_d;

  // First stage feeds only the second stage
  always_comb begin
    meta_d = async_in;
    sync_d = meta_q;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= meta_d;
      sync_q <= sync_d;
    end
  end

  assign sync_out = sync_q;
endmodule

// ### lmc_rx_route.sv
// Maps media input loss flags onto receive output lanes.
// Assumes a lane map input: entry k names the input lane feeding output lane k.
`timescale 1ns/1ps
module lmc_rx_route #(
  parameter int LANES = 8
) (
  input  wire logic [LANES-1:0]               in_lost,
  input  wire logic [LANES*$clog2(LANES)-1:0] lane_map,
  output logic      [LANES-1:0]               out_lost
);
  localparam int SW = $clog2(LANES);

  // One input may fan out to several outputs
  for (genvar k = 0; k < LANES; k++) begin : g_map
    assign out_lost[k] = in_lost[lane_map[k*SW +: SW]]; // R10
  end
endmodule

// ### lmc_top.sv
// Functional notes
// R1 - Tx output muted when disabled or squelched; disable decides behaviour when both.
// R2 - Disabled electrical Tx output is held quiescent.
// R3 - Tx disable follows host; data path state machine may hold it disabled.
// R4 - While Tx disabled, forced and automatic squelch are masked.
// R5 - Tx squelch on host force or automatically when host input unsuitable.
// R6 - Automatic Tx squelch may be absent for np application class.
// R7 - Host can switch each lane's automatic squelch controller off.
// R8 - Rx output muted by disable or squelch alone, no precedence.
// R9 - Rx disable comes only from host; disabled Rx output held quiescent.
// R10 - Rx output squelched when its mapped media input lane reports signal lost.
// R11 - Rx squelch held until valid input and resources ready.
// R12 - No host force of Rx squelch; only internal controller.
// R13 - Host should set equal auto-squelch settings within one data path.
// R14 - Per-lane control freezes host-side input equalizer adaptation.
// R15 - Per-lane command saves current equalizer setting for later recall.
// R16 - Per-lane host control inverts Rx output polarity.
// R17 - Tx input invert byte: bit k-1 is lane k, 1 inverts.
// R18 - Tx output disable byte: bit k-1 is media lane k, 1 disables.
// R19 - Tx squelch force byte: 1 forces squelch, 0 no effect.
// R20 - Tx auto squelch disable byte: 1 turns automatic squelch off.
// R21 - Equalizer save field: 01 slot one, 10 slot two, 00 and 11 reserved.
// R22 - Rx output polarity byte: 1 inverts lane polarity.
//
// Top of the lane output muting control: APB register file plus per-lane mute logic.
// Assumes APB master on pclk; pin status inputs are asynchronous and synchronised here.
`timescale 1ns/1ps
module lmc_top #(
  parameter int LANES   = lmc_pkg::LANES,
  parameter bit AUTO_TX = 1'b1
) (
  input  wire logic                           pclk,
  input  wire logic                           presetn,
  input  wire logic                           psel,
  input  wire logic                           penable,
  input  wire logic                           pwrite,
  input  wire logic [11:0]                    paddr,
  input  wire logic [31:0]                    pwdata,
  output logic      [31:0]                    prdata,
  output logic                                pready,
  output logic                                pslverr,
  input  wire logic [LANES-1:0]               dp_hold_off,
  input  wire logic [LANES-1:0]               tx_in_unsuitable,
  input  wire logic [LANES-1:0]               rx_signal_lost,
  input  wire logic [LANES-1:0]               rx_res_ready,
  input  wire logic [LANES*$clog2(LANES)-1:0] rx_lane_map,
  output logic      [LANES-1:0]               tx_out_quiet,
  output logic      [LANES-1:0]               tx_out_off_o,
  output logic      [LANES-1:0]               tx_out_mute_o,
  output logic      [LANES-1:0]               tx_in_invert_o,
  output logic      [LANES-1:0]               tx_eq_adapt_hold_o,
  output logic      [LANES-1:0]               tx_eq_save_slot1,
  output logic      [LANES-1:0]               tx_eq_save_slot2,
  output logic      [LANES-1:0]               rx_out_quiet,
  output logic      [LANES-1:0]               rx_out_off_o,
  output logic      [LANES-1:0]               rx_out_mute_o,
  output logic      [LANES-1:0]               rx_out_invert_o
);
  localparam int SW = lmc_pkg::SLOT_W;

  if (LANES != 8) begin : g_chk
    $error("lmc_top serves exactly eight lanes per bank");
  end

  // Control registers
  logic [LANES-1:0] tx_in_invert_q, tx_in_invert_d;
  logic [LANES-1:0] tx_out_off_q, tx_out_off_d;
  logic [LANES-1:0] tx_auto_mute_off_q, tx_auto_mute_off_d;
  logic [LANES-1:0] tx_out_mute_force_q, tx_out_mute_force_d;
  logic [LANES-1:0] tx_eq_adapt_hold_q, tx_eq_adapt_hold_d;
  logic [LANES-1:0] rx_out_invert_q, rx_out_invert_d;
  logic [LANES-1:0] rx_out_off_q, rx_out_off_d;
  logic [LANES-1:0] rx_auto_mute_off_q, rx_auto_mute_off_d;
  logic [LANES-1:0] save1_q, save1_d;
  logic [LANES-1:0] save2_q, save2_d;
  logic [7:0]       save_cnt_q, save_cnt_d;
  logic [31:0]      prdata_q, prdata_d;
  logic             pslverr_q, pslverr_d;
  logic             pready_q, pready_d;

  // Lane outputs
  logic [LANES-1:0] tx_quiet_q, tx_quiet_d;
  logic [LANES-1:0] tx_off_q, tx_off_d;
  logic [LANES-1:0] tx_mute_q, tx_mute_d;
  logic [LANES-1:0] rx_quiet_q, rx_quiet_d;
  logic [LANES-1:0] rx_mute_q, rx_mute_d;
  logic [LANES-1:0] rx_off_q, rx_off_d;

  // Synchronised pin levels
  logic [LANES-1:0] dp_hold_s, tx_unsuit_s, rx_lost_s, rx_unready_s;
  logic [LANES-1:0] rx_lost_mapped;

  // Ready travels inverted: a cleared synchroniser must not fake a not-ready squelch after reset
  lmc_sync #(.W(4*LANES)) u_sync (
    .pclk     (pclk),
    .presetn  (presetn),
    .async_in ({dp_hold_off, tx_in_unsuitable, rx_signal_lost, ~rx_res_ready}),
    .sync_out ({dp_hold_s, tx_unsuit_s, rx_lost_s, rx_unready_s})
  );

  lmc_rx_route #(.LANES(LANES)) u_route (
    .in_lost  (rx_lost_s),
    .lane_map (rx_lane_map),
    .out_lost (rx_lost_mapped)
  );

  // Word index decode, shared by read and write paths
  function automatic logic [7:0] word_idx(input logic [11:0] a);
    return a[9:2];
  endfunction

  // Save field decode; reserved codes give no save
  function automatic logic save_hit(input logic [1:0] f, input logic [1:0] code);
    return f == code; // R21
  endfunction

  logic       acc;
  logic [7:0] idx;
  assign acc = psel && penable && !pready_q;
  assign idx = word_idx(paddr);

  // APB register file; one wait state, answer in the cycle after the access phase starts
  always_comb begin
    tx_in_invert_d      = tx_in_invert_q;
    tx_out_off_d        = tx_out_off_q;
    tx_auto_mute_off_d  = tx_auto_mute_off_q;
    tx_out_mute_force_d = tx_out_mute_force_q;
    tx_eq_adapt_hold_d  = tx_eq_adapt_hold_q;
    rx_out_invert_d     = rx_out_invert_q;
    rx_out_off_d        = rx_out_off_q;
    rx_auto_mute_off_d  = rx_auto_mute_off_q;
    save1_d             = '0;
    save2_d             = '0;
    save_cnt_d          = save_cnt_q;
    prdata_d            = prdata_q;
    pslverr_d           = 1'b0;
    pready_d            = acc;
    if (acc && pwrite) begin
      unique case (idx)
        lmc_pkg::IDX_TX_IN_INVERT:     tx_in_invert_d      = pwdata[LANES-1:0]; // R17
        lmc_pkg::IDX_TX_OUT_OFF:       tx_out_off_d        = pwdata[LANES-1:0]; // R18
        lmc_pkg::IDX_TX_AUTO_MUTE_OFF: tx_auto_mute_off_d  = pwdata[LANES-1:0]; // R20
        lmc_pkg::IDX_TX_OUT_MUTE_FRC:  tx_out_mute_force_d = pwdata[LANES-1:0]; // R19
        lmc_pkg::IDX_TX_EQ_ADAPT_HOLD: tx_eq_adapt_hold_d  = pwdata[LANES-1:0]; // R14
        lmc_pkg::IDX_RX_OUT_INVERT:    rx_out_invert_d     = pwdata[LANES-1:0]; // R22
        lmc_pkg::IDX_RX_OUT_OFF:       rx_out_off_d        = pwdata[LANES-1:0];
        lmc_pkg::IDX_RX_AUTO_MUTE_OFF: rx_auto_mute_off_d  = pwdata[LANES-1:0]; // R7
        lmc_pkg::IDX_TX_EQ_SAVE_LO: begin
          // Write-only command; lanes 1..4 live in the low byte
          for (int k = 0; k < 4; k++) begin
            save1_d[k] = save_hit(pwdata[k*SW +: SW], lmc_pkg::EQ_SLOT_ONE); // R15
            save2_d[k] = save_hit(pwdata[k*SW +: SW], lmc_pkg::EQ_SLOT_TWO); // R15
          end
          save_cnt_d = save_cnt_q + 8'h01;
        end
        lmc_pkg::IDX_TX_EQ_SAVE_HI: begin
          for (int k = 0; k < 4; k++) begin
            save1_d[k+4] = save_hit(pwdata[k*SW +: SW], lmc_pkg::EQ_SLOT_ONE); // R15
            save2_d[k+4] = save_hit(pwdata[k*SW +: SW], lmc_pkg::EQ_SLOT_TWO); // R15
          end
          save_cnt_d = save_cnt_q + 8'h01;
        end
        lmc_pkg::IDX_TX_MUTE_STATUS,
        lmc_pkg::IDX_RX_MUTE_STATUS,
        lmc_pkg::IDX_EQ_SAVE_COUNT: pslverr_d = 1'b1; // Read-only
        default: pslverr_d = 1'b1;
      endcase
      // No register exists to force Rx squelch
      // R12
    end else if (acc) begin
      prdata_d = 32'h0000_0000;
      unique case (idx)
        lmc_pkg::IDX_TX_IN_INVERT:     prdata_d[LANES-1:0] = tx_in_invert_q;
        lmc_pkg::IDX_TX_OUT_OFF:       prdata_d[LANES-1:0] = tx_out_off_q;
        lmc_pkg::IDX_TX_AUTO_MUTE_OFF: prdata_d[LANES-1:0] = tx_auto_mute_off_q;
        lmc_pkg::IDX_TX_OUT_MUTE_FRC:  prdata_d[LANES-1:0] = tx_out_mute_force_q;
        lmc_pkg::IDX_TX_EQ_ADAPT_HOLD: prdata_d[LANES-1:0] = tx_eq_adapt_hold_q;
        lmc_pkg::IDX_TX_EQ_SAVE_LO,
        lmc_pkg::IDX_TX_EQ_SAVE_HI:    prdata_d[7:0] = lmc_pkg::RST_BYTE; // Write-only reads zero
        lmc_pkg::IDX_RX_OUT_INVERT:    prdata_d[LANES-1:0] = rx_out_invert_q;
        lmc_pkg::IDX_RX_OUT_OFF:       prdata_d[LANES-1:0] = rx_out_off_q;
        lmc_pkg::IDX_RX_AUTO_MUTE_OFF: prdata_d[LANES-1:0] = rx_auto_mute_off_q;
        lmc_pkg::IDX_TX_MUTE_STATUS:   prdata_d[15:0] = {tx_off_q, tx_mute_q};
        lmc_pkg::IDX_RX_MUTE_STATUS:   prdata_d[15:0] = {rx_out_off_q, rx_mute_q};
        lmc_pkg::IDX_EQ_SAVE_COUNT:    prdata_d[7:0] = save_cnt_q;
        default:                       pslverr_d = 1'b1;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_in_invert_q      <= '0;
      tx_out_off_q        <= '0;
      tx_auto_mute_off_q  <= '0;
      tx_out_mute_force_q <= '0;
      tx_eq_adapt_hold_q  <= '0;
      rx_out_invert_q     <= '0;
      rx_out_off_q        <= '0;
      rx_auto_mute_off_q  <= '0;
      save1_q             <= '0;
      save2_q             <= '0;
      save_cnt_q          <= 8'h00;
      prdata_q            <= 32'h0000_0000;
      pslverr_q           <= 1'b0;
      pready_q            <= 1'b0;
    end else begin
      tx_in_invert_q      <= tx_in_invert_d;
      tx_out_off_q        <= tx_out_off_d;
      tx_auto_mute_off_q  <= tx_auto_mute_off_d;
      tx_out_mute_force_q <= tx_out_mute_force_d;
      tx_eq_adapt_hold_q  <= tx_eq_adapt_hold_d;
      rx_out_invert_q     <= rx_out_invert_d;
      rx_out_off_q        <= rx_out_off_d;
      rx_auto_mute_off_q  <= rx_auto_mute_off_d;
      save1_q             <= save1_d;
      save2_q             <= save2_d;
      save_cnt_q          <= save_cnt_d;
      prdata_q            <= prdata_d;
      pslverr_q           <= pslverr_d;
      pready_q            <= pready_d;
    end
  end

  // Per-lane muting; outputs lag register writes by one cycle
  always_comb begin
    for (int k = 0; k < LANES; k++) begin
      // Host bit or data path hold keeps output disabled
      tx_off_d[k] = tx_out_off_q[k] || dp_hold_s[k]; // R3
      // Automatic squelch only when built and not switched off
      tx_mute_d[k] = !tx_off_d[k] && // R4
                     (tx_out_mute_force_q[k] || // R5
                      (AUTO_TX && !tx_auto_mute_off_q[k] && tx_unsuit_s[k])); // R6 R7
      // Disable wins; quiet either way
      tx_quiet_d[k] = tx_off_d[k] || tx_mute_d[k]; // R1 R2
      // Squelch until input valid and resources ready
      rx_mute_d[k] = !rx_auto_mute_off_q[k] && (rx_lost_mapped[k] || rx_unready_s[k]); // R11
      // Disable staged like the quiet flag so both move in the same cycle
      rx_off_d[k]   = rx_out_off_q[k]; // R9
      rx_quiet_d[k] = rx_out_off_q[k] || rx_mute_d[k]; // R8 R9
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_off_q   <= '0;
      tx_mute_q  <= '0;
      tx_quiet_q <= '0;
      rx_mute_q  <= '0;
      rx_off_q   <= '0;
      rx_quiet_q <= '0;
    end else begin
      tx_off_q   <= tx_off_d;
      tx_mute_q  <= tx_mute_d;
      tx_quiet_q <= tx_quiet_d;
      rx_mute_q  <= rx_mute_d;
      rx_off_q   <= rx_off_d;
      rx_quiet_q <= rx_quiet_d;
    end
  end

  // Port drive, all from flip-flops
  assign prdata             = prdata_q;
  assign pready             = pready_q;
  assign pslverr            = pslverr_q;
  assign tx_out_quiet       = tx_quiet_q;
  assign tx_out_off_o       = tx_off_q;
  assign tx_out_mute_o      = tx_mute_q;
  assign tx_in_invert_o     = tx_in_invert_q; // R17
  assign tx_eq_adapt_hold_o = tx_eq_adapt_hold_q; // R14
  assign tx_eq_save_slot1   = save1_q;
  assign tx_eq_save_slot2   = save2_q;
  assign rx_out_quiet       = rx_quiet_q;
  assign rx_out_off_o       = rx_off_q;
  assign rx_out_mute_o      = rx_mute_q;
  assign rx_out_invert_o    = rx_out_invert_q; // R16
endmodule

// ### lmc_top_checker_assertions.sv
// Checker for the lane output muting control top: APB handshake and mute relations.
// Assumes it is bound to lmc_top and sees only its ports.
`timescale 1ns/1ps
module lmc_top_checker #(
  parameter int LANES = 8
) (
  input wire logic             pclk,
  input wire logic             presetn,
  input wire logic             psel,
  input wire logic             penable,
  input wire logic             pwrite,
  input wire logic             pready,
  input wire logic             pslverr,
  input wire logic [LANES-1:0] rx_signal_lost,
  input wire logic [LANES-1:0] rx_res_ready,
  input wire logic [LANES-1:0] tx_out_quiet,
  input wire logic [LANES-1:0] tx_out_off_o,
  input wire logic [LANES-1:0] tx_out_mute_o,
  input wire logic [LANES-1:0] rx_out_quiet,
  input wire logic [LANES-1:0] rx_out_off_o,
  input wire logic [LANES-1:0] rx_out_mute_o,
  input wire logic [LANES-1:0] rx_out_invert_o
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Handshake: exactly one wait state, one-cycle answer
  a_ready_wait: assert property (psel && penable && !pready |=> pready) else $error("pready not one cycle after access");
  a_ready_pulse: assert property (pready |=> !pready) else $error("pready held longer than one cycle");
  a_err_ready: assert property (pslverr |-> pready && $past(psel && penable)) else $error("pslverr outside answer");
  // Mute relations per lane
  a_tx_off_wins: assert property ((tx_out_off_o & tx_out_mute_o) == '0) else $error("squelch not masked");
  a_tx_quiet_or: assert property (tx_out_quiet == (tx_out_off_o | tx_out_mute_o)) else $error("tx quiet wrong");
  a_rx_quiet_or: assert property (rx_out_quiet == (rx_out_off_o | rx_out_mute_o)) else $error("rx quiet wrong");
  // Synchroniser delay allows two to four cycles from the pin
  a_rx_mute_cause: assert property ($rose(|rx_out_mute_o) |-> $past(|rx_signal_lost || !(&rx_res_ready), 2)
    || $past(|rx_signal_lost || !(&rx_res_ready), 3) || $past(|rx_signal_lost || !(&rx_res_ready), 4))
    else $error("rx squelch without cause");
  a_rx_cfg_write: assert property ($changed(rx_out_off_o) || $changed(rx_out_invert_o) |->
    $past(psel && penable && pwrite, 1) || $past(psel && penable && pwrite, 2)) else $error("rx setting moved");
endmodule

// ### lmc_host.sv
// Host model: APB master that writes and reads the per-lane control bytes.
// Assumes a slave answering with pready; address and data are scrambled while idle.
`timescale 1ns/1ps
module lmc_host (
  input  wire logic        pclk,
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic [11:0]      paddr,
  output logic [31:0]      pwdata,
  input  wire logic [31:0] prdata,
  input  wire logic        pready,
  input  wire logic        pslverr
);
  // Idle bus at time zero
  initial begin
    psel = 1'h0;
    penable = 1'h0;
    pwrite = 1'h0;
    paddr = 12'h000;
    pwdata = 32'h0;
  end
  // One transfer; waits for pready with no cycle count assumed
  task automatic xfer(input logic w, input logic [7:0] idx, input logic [31:0] wd,
                      output logic [31:0] rd, output logic err);
    @(posedge pclk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= {2'h0, idx, 2'h0};
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'h1;
    do @(posedge pclk); while (pready !== 1'h1);
    rd = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    paddr <= ~paddr; // Stale address must not be trusted
    pwdata <= ~pwdata;
  endtask
endmodule

// ### lmc_top_tb_top.sv
// Testbench for the lane output muting control: host model on APB, bench on lane pins.
// Assumes lmc_pkg, lmc_top, lmc_host and the checker are compiled first.
`timescale 1ns/1ps
module lmc_top_tb_top;
  logic        pclk = 1'h0, presetn = 1'h0, psel, penable, pwrite, pready, pslverr, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [7:0]  dp_hold_off = 8'h0, tx_in_unsuitable = 8'h0, rx_signal_lost = 8'h0, rx_res_ready = 8'hFF;
  logic [23:0] rx_lane_map = {3'h7, 3'h6, 3'h5, 3'h4, 3'h3, 3'h2, 3'h0, 3'h0};
  logic [7:0]  tx_out_quiet, tx_out_off_o, tx_out_mute_o, tx_in_invert_o, tx_eq_adapt_hold_o, tx_eq_save_slot1;
  logic [7:0]  tx_eq_save_slot2, rx_out_quiet, rx_out_off_o, rx_out_mute_o, rx_out_invert_o, seen1, seen2;
  int          n_errors = 0, compares = 0, cyc = 0;
  always #50 pclk = ~pclk;
  lmc_top u_lmc_top (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .dp_hold_off, .tx_in_unsuitable, .rx_signal_lost, .rx_res_ready, .rx_lane_map, .tx_out_quiet, .tx_out_off_o,
    .tx_out_mute_o, .tx_in_invert_o, .tx_eq_adapt_hold_o, .tx_eq_save_slot1, .tx_eq_save_slot2, .rx_out_quiet,
    .rx_out_off_o, .rx_out_mute_o, .rx_out_invert_o);
  lmc_host u_lmc_host (.pclk, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr);
  // Save pulses last one cycle; catch them mid-cycle
  always @(negedge pclk) begin
    seen1 = seen1 | tx_eq_save_slot1;
    seen2 = seen2 | tx_eq_save_slot2;
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] idx, input logic [31:0] d);
    u_lmc_host.xfer(1'h1, idx, d, rd, err);
    repeat (2) @(posedge pclk);
  endtask
  task automatic rdc(input logic [7:0] idx, input logic [7:0] exp, input logic e);
    u_lmc_host.xfer(1'h0, idx, 32'h0, rd, err);
    chk({7'h0, err}, {7'h0, e});
    if (!e) chk(rd[7:0], exp);
  endtask
  task automatic pins(input logic [7:0] dp, un, lost, rdy);
    @(posedge pclk);
    dp_hold_off <= dp;
    tx_in_unsuitable <= un;
    rx_signal_lost <= lost;
    rx_res_ready <= rdy;
    repeat (5) @(posedge pclk);
  endtask
  task automatic t_regs;
    logic [7:0] idx [8] = '{8'h81, 8'h82, 8'h83, 8'h84, 8'h86, 8'h89, 8'hA0, 8'hA1};
    foreach (idx[i]) rdc(idx[i], 8'h00, 1'h0);
    foreach (idx[i]) begin
      wr(idx[i], 32'hA5);
      rdc(idx[i], 8'hA5, 1'h0);
      wr(idx[i], 32'h0);
    end
    rdc(8'h85, 8'h00, 1'h1);
    rdc(8'h87, 8'h00, 1'h0);
    u_lmc_host.xfer(1'h1, 8'hA2, 32'hFF, rd, err);
    chk({7'h0, err}, 8'h01);
    $display("t_regs done");
  endtask
  task automatic t_tx;
    wr(8'h81, 32'h01);
    chk(tx_in_invert_o, 8'h01);
    wr(8'h82, 32'h03);
    wr(8'h84, 32'h06);
    chk(tx_out_off_o, 8'h03);
    chk(tx_out_mute_o, 8'h04);
    chk(tx_out_quiet, 8'h07);
    wr(8'h82, 32'h0);
    wr(8'h84, 32'h0);
    pins(8'h10, 8'h30, 8'h00, 8'hFF);
    chk(tx_out_off_o, 8'h10);
    chk(tx_out_mute_o, 8'h20);
    rdc(8'hA2, 8'h20, 1'h0);
    wr(8'h83, 32'h20);
    chk(tx_out_mute_o, 8'h00);
    wr(8'h83, 32'h0);
    pins(8'h00, 8'h00, 8'h00, 8'hFF);
    $display("t_tx done");
  endtask
  task automatic t_rx;
    pins(8'h00, 8'h00, 8'h01, 8'hFF);
    chk(rx_out_mute_o, 8'h03);
    pins(8'h00, 8'h00, 8'h00, 8'hFD);
    chk(rx_out_mute_o, 8'h02);
    wr(8'hA0, 32'h80);
    chk(rx_out_off_o, 8'h80);
    chk(rx_out_quiet, 8'h82);
    rdc(8'hA3, 8'h02, 1'h0);
    wr(8'hA1, 32'hFF);
    chk(rx_out_mute_o, 8'h00);
    wr(8'h89, 32'h40);
    chk(rx_out_invert_o, 8'h40);
    wr(8'hA0, 32'h0);
    wr(8'hA1, 32'h0);
    pins(8'h00, 8'h00, 8'h00, 8'hFF);
    $display("t_rx done");
  endtask
  task automatic t_eq;
    wr(8'h86, 32'h81);
    chk(tx_eq_adapt_hold_o, 8'h81);
    seen1 = 8'h00;
    seen2 = 8'h00;
    wr(8'h87, 32'hE4);
    wr(8'h88, 32'h1B);
    chk(seen1, 8'h42);
    chk(seen2, 8'h24);
    rdc(8'hA4, 8'h02, 1'h0);
    $display("t_eq done");
  endtask
  // Main sequence
  initial begin
    repeat (4) @(posedge pclk);
    presetn <= 1'h1;
    t_regs;
    t_tx;
    t_rx;
    t_eq;
    test_done;
  end
  // Hang guard, far above the few hundred cycles needed
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin
      n_errors++;
      test_done;
    end
  end
  task automatic test_done;
    $display("errors %0d compares %0d", n_errors, compares);
    if (n_errors == 0 && compares > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
endmodule
bind lmc_top lmc_top_checker #(.LANES(LANES)) u_lmc_top_checker (.pclk, .presetn, .psel, .penable, .pwrite,
  .pready, .pslverr, .rx_signal_lost, .rx_res_ready, .tx_out_quiet, .tx_out_off_o, .tx_out_mute_o,
  .rx_out_quiet, .rx_out_off_o, .rx_out_mute_o, .rx_out_invert_o);
